// >>> design/cpu_regs_pkg.sv
// Constants for the programmer-visible register set and flag register
`default_nettype none
package cpu_regs_pkg;
	// Widths
	localparam int DATA_W = 16;
	localparam int LONG_W = 20;
	localparam int BUS_W = 32;
	localparam int FLAGS_W = 11;
	localparam int IPL_W = 3;
	localparam int IDX_W = 5;
	localparam int SW_INT_W = 6;
	// Register indices on the software port
	localparam logic [4:0] IDX_DATA_REG_0 = 5'h00;
	localparam logic [4:0] IDX_DATA_REG_1 = 5'h01;
	localparam logic [4:0] IDX_DATA_REG_2 = 5'h02;
	localparam logic [4:0] IDX_DATA_REG_3 = 5'h03;
	localparam logic [4:0] IDX_ADDR_REG_0 = 5'h04;
	localparam logic [4:0] IDX_ADDR_REG_1 = 5'h05;
	localparam logic [4:0] IDX_FRAME_BASE = 5'h06;
	localparam logic [4:0] IDX_VECTOR_TABLE_BASE = 5'h07;
	localparam logic [4:0] IDX_PROGRAM_COUNTER = 5'h08;
	localparam logic [4:0] IDX_USER_STACK_POINTER = 5'h09;
	localparam logic [4:0] IDX_INTERRUPT_STACK_POINTER = 5'h0a;
	localparam logic [4:0] IDX_STATIC_BASE = 5'h0b;
	localparam logic [4:0] IDX_CPU_FLAGS = 5'h0c;
	localparam logic [4:0] IDX_DATA_REG_0_HIGH_BYTE = 5'h0d;
	localparam logic [4:0] IDX_DATA_REG_0_LOW_BYTE = 5'h0e;
	localparam logic [4:0] IDX_DATA_REG_1_HIGH_BYTE = 5'h0f;
	localparam logic [4:0] IDX_DATA_REG_1_LOW_BYTE = 5'h10;
	localparam logic [4:0] IDX_DATA_PAIR_LOW = 5'h11;
	localparam logic [4:0] IDX_DATA_PAIR_HIGH = 5'h12;
	localparam logic [4:0] IDX_ADDR_PAIR = 5'h13;
	localparam logic [4:0] IDX_STACK_POINTER = 5'h14;
	// Flag bit positions in cpu_flags
	localparam int FLG_CARRY = 0;
	localparam int FLG_DEBUG = 1;
	localparam int FLG_ZERO = 2;
	localparam int FLG_SIGN = 3;
	localparam int FLG_BANK = 4;
	localparam int FLG_OVERFLOW = 5;
	localparam int FLG_INT_EN = 6;
	localparam int FLG_STACK_SEL = 7;
	localparam int FLG_IPL_LSB = 8;
	localparam int FLG_IPL_MSB = 10;
	// Reset values
	localparam logic [10:0] FLAGS_RST = 11'h000;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [19:0] LONG_RST = 20'h00000;
	// Highest software interrupt number that forces the interrupt stack
	localparam logic [5:0] SW_INT_STACK_MAX = 6'h1f;
endpackage
`default_nettype wire

// >>> design/cpu_register_set.sv
// Programmer-visible register set with two banks and the flag register
//
// Functional notes
// - Thirteen registers; data, address and frame base exist in two banks.
// - Bank flag 0 selects bank zero, 1 selects bank one, for banked access.
// - Four 16-bit data registers for transfers and arithmetic.
// - Data registers zero and one split into independent high and low bytes.
// - Data two:zero and three:one form 32-bit pairs, higher number on top.
// - Two 16-bit address registers; combined 32-bit form has register one on top.
// - Vector table base is 20 bits, start of the interrupt vector table.
// - Program counter is 20 bits, address of the next instruction.
// - Two 16-bit stack pointers; stack flag 0 picks interrupt, 1 picks user.
// - Stack flag cleared on hardware interrupt or software interrupt 0 to 31.
// - Static base and frame base are 16-bit base registers.
// - Flag register is 11 bits holding all status flags and the priority level.
// - Carry flag captures carry, borrow or shifted-out bit of the ALU.
// - Zero flag is 1 for a zero result, else 0.
// - Sign flag is 1 for a negative result, else 0.
// - Overflow flag is 1 when the operation overflows, else 0.
// - Interrupt enable gates maskable interrupts; cleared on interrupt acceptance.
// - Priority level field is three bits, levels 0 to 7.
// - Interrupt enabled only if its priority is above the current level.
// - Reserved flag bits written as 0; their read value is undefined.
`default_nettype none
module cpu_register_set
	import cpu_regs_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// Software register port
	input wire logic [IDX_W-1:0] i_addr,
	input wire logic [BUS_W-1:0] i_wdata,
	input wire logic i_we,
	input wire logic i_re,
	output logic [BUS_W-1:0] o_rdata,
	// ALU flag update
	input wire logic i_alu_flag_we,
	input wire logic i_alu_carry,
	input wire logic i_alu_overflow,
	input wire logic [DATA_W-1:0] i_alu_result,
	// Interrupt acceptance
	input wire logic i_int_req,
	input wire logic [IPL_W-1:0] i_int_prio,
	input wire logic i_hw_int_accept,
	input wire logic i_sw_int_exec,
	input wire logic [SW_INT_W-1:0] i_sw_int_num,
	output logic o_int_enabled,
	// Status for the datapath
	output logic [FLAGS_W-1:0] o_flags,
	output logic [LONG_W-1:0] o_program_counter,
	output logic [LONG_W-1:0] o_vector_table_base,
	output logic [DATA_W-1:0] o_stack_pointer
);

	typedef struct packed {
		logic [1:0][3:0][DATA_W-1:0] data;
		logic [1:0][1:0][DATA_W-1:0] addr;
		logic [1:0][DATA_W-1:0] fb;
		logic [LONG_W-1:0] vtb;
		logic [LONG_W-1:0] pc;
		logic [DATA_W-1:0] user_stack_pointer;
		logic [DATA_W-1:0] interrupt_stack_pointer;
		logic [DATA_W-1:0] sb;
		logic [IPL_W-1:0] processor_priority_level;
		logic u;
		logic ie;
		logic ov;
		logic bank;
		logic sg;
		logic zr;
		logic dbg;
		logic cy;
		logic [BUS_W-1:0] rdata;
	} state_t;

	state_t s;
	state_t next_s;
	logic [FLAGS_W-1:0] flags_word;

	// Flag register image, every one of the eleven bits assigned
	always_comb begin
		flags_word = FLAGS_RST;
		flags_word[FLG_CARRY] = s.cy;
		flags_word[FLG_DEBUG] = s.dbg;
		flags_word[FLG_ZERO] = s.zr;
		flags_word[FLG_SIGN] = s.sg;
		flags_word[FLG_BANK] = s.bank;
		flags_word[FLG_OVERFLOW] = s.ov;
		flags_word[FLG_INT_EN] = s.ie;
		flags_word[FLG_STACK_SEL] = s.u;
		flags_word[FLG_IPL_MSB:FLG_IPL_LSB] = s.processor_priority_level;
	end

	// Next-state logic: reads, software writes, then hardware flag updates
	always_comb begin
		next_s = s;
		next_s.rdata = '0; // Read data stands for one cycle only
		// Read side; banked names follow the bank flag
		if (i_re) begin
			case (i_addr)
				IDX_DATA_REG_0: next_s.rdata = BUS_W'(s.data[s.bank][0]);
				IDX_DATA_REG_1: next_s.rdata = BUS_W'(s.data[s.bank][1]);
				IDX_DATA_REG_2: next_s.rdata = BUS_W'(s.data[s.bank][2]);
				IDX_DATA_REG_3: next_s.rdata = BUS_W'(s.data[s.bank][3]);
				IDX_ADDR_REG_0: next_s.rdata = BUS_W'(s.addr[s.bank][0]);
				IDX_ADDR_REG_1: next_s.rdata = BUS_W'(s.addr[s.bank][1]);
				IDX_FRAME_BASE: next_s.rdata = BUS_W'(s.fb[s.bank]);
				IDX_VECTOR_TABLE_BASE: next_s.rdata = BUS_W'(s.vtb);
				IDX_PROGRAM_COUNTER: next_s.rdata = BUS_W'(s.pc);
				IDX_USER_STACK_POINTER: next_s.rdata = BUS_W'(s.user_stack_pointer);
				IDX_INTERRUPT_STACK_POINTER: next_s.rdata = BUS_W'(s.interrupt_stack_pointer);
				IDX_STATIC_BASE: next_s.rdata = BUS_W'(s.sb);
				IDX_CPU_FLAGS: next_s.rdata = BUS_W'(flags_word);
				IDX_DATA_REG_0_HIGH_BYTE: next_s.rdata = BUS_W'(s.data[s.bank][0][DATA_W-1:DATA_W/2]);
				IDX_DATA_REG_0_LOW_BYTE: next_s.rdata = BUS_W'(s.data[s.bank][0][DATA_W/2-1:0]);
				IDX_DATA_REG_1_HIGH_BYTE: next_s.rdata = BUS_W'(s.data[s.bank][1][DATA_W-1:DATA_W/2]);
				IDX_DATA_REG_1_LOW_BYTE: next_s.rdata = BUS_W'(s.data[s.bank][1][DATA_W/2-1:0]);
				IDX_DATA_PAIR_LOW: next_s.rdata = {s.data[s.bank][2], s.data[s.bank][0]};
				IDX_DATA_PAIR_HIGH: next_s.rdata = {s.data[s.bank][3], s.data[s.bank][1]};
				IDX_ADDR_PAIR: next_s.rdata = {s.addr[s.bank][1], s.addr[s.bank][0]};
				IDX_STACK_POINTER: next_s.rdata = BUS_W'(s.u ? s.user_stack_pointer : s.interrupt_stack_pointer);
				default: next_s.rdata = '0; // Unmapped index reads as zero
			endcase
		end
		// Write side; narrow registers take the low bits of the word
		if (i_we) begin
			case (i_addr)
				IDX_DATA_REG_0: next_s.data[s.bank][0] = i_wdata[DATA_W-1:0];
				IDX_DATA_REG_1: next_s.data[s.bank][1] = i_wdata[DATA_W-1:0];
				IDX_DATA_REG_2: next_s.data[s.bank][2] = i_wdata[DATA_W-1:0];
				IDX_DATA_REG_3: next_s.data[s.bank][3] = i_wdata[DATA_W-1:0];
				IDX_ADDR_REG_0: next_s.addr[s.bank][0] = i_wdata[DATA_W-1:0];
				IDX_ADDR_REG_1: next_s.addr[s.bank][1] = i_wdata[DATA_W-1:0];
				IDX_FRAME_BASE: next_s.fb[s.bank] = i_wdata[DATA_W-1:0];
				IDX_VECTOR_TABLE_BASE: next_s.vtb = i_wdata[LONG_W-1:0];
				IDX_PROGRAM_COUNTER: next_s.pc = i_wdata[LONG_W-1:0];
				IDX_USER_STACK_POINTER: next_s.user_stack_pointer = i_wdata[DATA_W-1:0];
				IDX_INTERRUPT_STACK_POINTER: next_s.interrupt_stack_pointer = i_wdata[DATA_W-1:0];
				IDX_STATIC_BASE: next_s.sb = i_wdata[DATA_W-1:0];
				IDX_CPU_FLAGS: begin
					next_s.cy = i_wdata[FLG_CARRY];
					next_s.dbg = i_wdata[FLG_DEBUG];
					next_s.zr = i_wdata[FLG_ZERO];
					next_s.sg = i_wdata[FLG_SIGN];
					next_s.bank = i_wdata[FLG_BANK];
					next_s.ov = i_wdata[FLG_OVERFLOW];
					next_s.ie = i_wdata[FLG_INT_EN];
					next_s.u = i_wdata[FLG_STACK_SEL];
					next_s.processor_priority_level = i_wdata[FLG_IPL_MSB:FLG_IPL_LSB];
				end
				IDX_DATA_REG_0_HIGH_BYTE: next_s.data[s.bank][0][DATA_W-1:DATA_W/2] = i_wdata[DATA_W/2-1:0];
				IDX_DATA_REG_0_LOW_BYTE: next_s.data[s.bank][0][DATA_W/2-1:0] = i_wdata[DATA_W/2-1:0];
				IDX_DATA_REG_1_HIGH_BYTE: next_s.data[s.bank][1][DATA_W-1:DATA_W/2] = i_wdata[DATA_W/2-1:0];
				IDX_DATA_REG_1_LOW_BYTE: next_s.data[s.bank][1][DATA_W/2-1:0] = i_wdata[DATA_W/2-1:0];
				IDX_DATA_PAIR_LOW: begin
					next_s.data[s.bank][2] = i_wdata[BUS_W-1:DATA_W];
					next_s.data[s.bank][0] = i_wdata[DATA_W-1:0];
				end
				IDX_DATA_PAIR_HIGH: begin
					next_s.data[s.bank][3] = i_wdata[BUS_W-1:DATA_W];
					next_s.data[s.bank][1] = i_wdata[DATA_W-1:0];
				end
				IDX_ADDR_PAIR: begin
					next_s.addr[s.bank][1] = i_wdata[BUS_W-1:DATA_W];
					next_s.addr[s.bank][0] = i_wdata[DATA_W-1:0];
				end
				IDX_STACK_POINTER: begin
					if (s.u) begin
						next_s.user_stack_pointer = i_wdata[DATA_W-1:0];
					end else begin
						next_s.interrupt_stack_pointer = i_wdata[DATA_W-1:0];
					end
				end
				default: ; // Unmapped writes are dropped
			endcase
		end
		// ALU results after software so a same-cycle flag write loses to hardware
		if (i_alu_flag_we) begin
			next_s.cy = i_alu_carry;
			next_s.zr = (i_alu_result == WORD_RST);
			next_s.sg = i_alu_result[DATA_W-1];
			next_s.ov = i_alu_overflow;
		end
		// Interrupt acceptance overrides any software write of the same flags
		if (i_hw_int_accept) begin
			next_s.ie = 1'b0;
			next_s.u = 1'b0;
		end
		if (i_sw_int_exec) begin
			next_s.ie = 1'b0;
			if (i_sw_int_num <= SW_INT_STACK_MAX) begin
				next_s.u = 1'b0;
			end
		end
	end

	// State register; reset values are constants only
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Outputs; the enable check is combinational so the sequencer sees it at once
	assign o_rdata = s.rdata;
	assign o_flags = flags_word;
	assign o_program_counter = s.pc;
	assign o_vector_table_base = s.vtb;
	assign o_stack_pointer = s.u ? s.user_stack_pointer : s.interrupt_stack_pointer;
	assign o_int_enabled = i_int_req && s.ie && (i_int_prio > s.processor_priority_level);

	// Checks on the flag and register behaviour
	property p_int_accept_clears;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_hw_int_accept |=> !o_flags[FLG_INT_EN] && !o_flags[FLG_STACK_SEL];
	endproperty
	a_int_accept_clears: assert property (p_int_accept_clears) else $error("accept left I or U set");

	property p_sw_int_stack;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_sw_int_exec && (i_sw_int_num <= SW_INT_STACK_MAX) |=> !o_flags[FLG_STACK_SEL];
	endproperty
	a_sw_int_stack: assert property (p_sw_int_stack) else $error("low software interrupt kept U");

	property p_sw_int_high_keeps;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_sw_int_exec && (i_sw_int_num > SW_INT_STACK_MAX) && !i_hw_int_accept && !i_we
			|=> o_flags[FLG_STACK_SEL] == $past(o_flags[FLG_STACK_SEL]);
	endproperty
	a_sw_int_high_keeps: assert property (p_sw_int_high_keeps) else $error("high software interrupt changed U");

	property p_zero_flag;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_alu_flag_we |=> o_flags[FLG_ZERO] == ($past(i_alu_result) == WORD_RST);
	endproperty
	a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

	property p_sign_flag;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_alu_flag_we |=> o_flags[FLG_SIGN] == $past(i_alu_result[DATA_W-1]);
	endproperty
	a_sign_flag: assert property (p_sign_flag) else $error("sign flag wrong");

	property p_carry_ovf;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_alu_flag_we |=> o_flags[FLG_CARRY] == $past(i_alu_carry) && o_flags[FLG_OVERFLOW] == $past(i_alu_overflow);
	endproperty
	a_carry_ovf: assert property (p_carry_ovf) else $error("carry or overflow wrong");

	property p_prio_gate;
		@(posedge i_clk) disable iff (!i_arst_n)
		o_int_enabled |-> o_flags[FLG_INT_EN] && (i_int_prio > o_flags[FLG_IPL_MSB:FLG_IPL_LSB]);
	endproperty
	a_prio_gate: assert property (p_prio_gate) else $error("interrupt enabled at or below level");

	property p_bank_read;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_re && (i_addr == IDX_DATA_REG_0) |=> o_rdata[15:0] == $past(s.data[s.bank][0]);
	endproperty
	a_bank_read: assert property (p_bank_read) else $error("banked read from wrong bank");

	property p_pair_read;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_re && (i_addr == IDX_DATA_PAIR_LOW) |=> o_rdata == {$past(s.data[s.bank][2]), $past(s.data[s.bank][0])};
	endproperty
	a_pair_read: assert property (p_pair_read) else $error("data pair order wrong");

	property p_byte_write;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_we && (i_addr == IDX_DATA_REG_0_HIGH_BYTE)
			|=> s.data[$past(s.bank)][0] == {$past(i_wdata[7:0]), $past(s.data[s.bank][0][7:0])};
	endproperty
	a_byte_write: assert property (p_byte_write) else $error("byte write touched other byte");

	property p_sp_select;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_re && (i_addr == IDX_STACK_POINTER) |=> o_rdata[15:0] == ($past(s.u) ? $past(s.user_stack_pointer) : $past(s.interrupt_stack_pointer));
	endproperty
	a_sp_select: assert property (p_sp_select) else $error("stack pointer select wrong");

	property p_read_one_cycle;
		@(posedge i_clk) disable iff (!i_arst_n)
		!i_re |=> o_rdata == '0;
	endproperty
	a_read_one_cycle: assert property (p_read_one_cycle) else $error("read data held too long");

	// Further checks on reset, register writes and reads, and interrupt side effects
	property p_reset_flags;
		@(posedge i_clk) $rose(i_arst_n) |-> o_flags == FLAGS_RST && o_stack_pointer == WORD_RST;
	endproperty
	a_reset_flags: assert property (p_reset_flags) else $error("flags not clear after reset");

	property p_bank_write;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_we && (i_addr == IDX_DATA_REG_0)
			|=> s.data[$past(s.bank)][0] == $past(i_wdata[DATA_W-1:0])
			&& s.data[!$past(s.bank)][0] == $past(s.data[!s.bank][0]);
	endproperty
	a_bank_write: assert property (p_bank_write) else $error("banked write reached other bank");

	property p_addr_pair_write;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_we && (i_addr == IDX_ADDR_PAIR)
			|=> {s.addr[$past(s.bank)][1], s.addr[$past(s.bank)][0]} == $past(i_wdata);
	endproperty
	a_addr_pair_write: assert property (p_addr_pair_write) else $error("address pair order wrong");

	property p_ipl_kept;
		@(posedge i_clk) disable iff (!i_arst_n)
		(i_hw_int_accept || i_sw_int_exec) && !(i_we && (i_addr == IDX_CPU_FLAGS))
			|=> o_flags[FLG_IPL_MSB:FLG_IPL_LSB] == $past(o_flags[FLG_IPL_MSB:FLG_IPL_LSB]);
	endproperty
	a_ipl_kept: assert property (p_ipl_kept) else $error("interrupt changed priority level");

	property p_sw_int_clears_ie;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_sw_int_exec |=> !o_flags[FLG_INT_EN];
	endproperty
	a_sw_int_clears_ie: assert property (p_sw_int_clears_ie) else $error("software interrupt left I set");

	property p_pc_write;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_we && (i_addr == IDX_PROGRAM_COUNTER) |=> o_program_counter == $past(i_wdata[LONG_W-1:0]);
	endproperty
	a_pc_write: assert property (p_pc_write) else $error("program counter write lost");

	property p_vtb_write;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_we && (i_addr == IDX_VECTOR_TABLE_BASE) |=> o_vector_table_base == $past(i_wdata[LONG_W-1:0]);
	endproperty
	a_vtb_write: assert property (p_vtb_write) else $error("vector table base write lost");

	property p_word_write;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_we && (i_addr == IDX_DATA_REG_3) |=> s.data[$past(s.bank)][3] == $past(i_wdata[DATA_W-1:0]);
	endproperty
	a_word_write: assert property (p_word_write) else $error("data word write lost");

	property p_static_base_write;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_we && (i_addr == IDX_STATIC_BASE) |=> s.sb == $past(i_wdata[DATA_W-1:0]);
	endproperty
	a_static_base_write: assert property (p_static_base_write) else $error("static base write lost");

	property p_unmapped_read;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_re && (i_addr > IDX_STACK_POINTER) |=> o_rdata == '0;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped index read nonzero");

	property p_flags_read;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_re && (i_addr == IDX_CPU_FLAGS) |=> o_rdata == BUS_W'($past(o_flags));
	endproperty
	a_flags_read: assert property (p_flags_read) else $error("flag register read wrong");

	// Main scenarios
	c_bank_one_read: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		s.bank && i_re && (i_addr == IDX_DATA_REG_0));
	c_hw_accept: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		o_int_enabled ##1 i_hw_int_accept);
	c_alu_zero: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		i_alu_flag_we && (i_alu_result == WORD_RST));
	c_sw_int_high: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		i_sw_int_exec && (i_sw_int_num > SW_INT_STACK_MAX));
	c_pair_high_write: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		i_we && (i_addr == IDX_DATA_PAIR_HIGH));

endmodule // cpu_register_set
`default_nettype wire

// >>> testbench/cpu_register_set_tb_top.sv
// Self-checking bench for the CPU register set and flag register
`default_nettype none
module cpu_register_set_tb_top import cpu_regs_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	// Design inputs, all given a value at time zero
	logic i_clk = 1'h0;
	logic i_arst_n = 1'h0;
	logic [IDX_W-1:0] i_addr = '0;
	logic [BUS_W-1:0] i_wdata = '0;
	logic i_we = 1'h0;
	logic i_re = 1'h0;
	logic i_alu_flag_we = 1'h0;
	logic i_alu_carry = 1'h0;
	logic i_alu_overflow = 1'h0;
	logic [DATA_W-1:0] i_alu_result = '0;
	logic i_int_req = 1'h0;
	logic [IPL_W-1:0] i_int_prio = '0;
	logic i_hw_int_accept = 1'h0;
	logic i_sw_int_exec = 1'h0;
	logic [SW_INT_W-1:0] i_sw_int_num = '0;
	logic [BUS_W-1:0] o_rdata;
	logic o_int_enabled;
	logic [FLAGS_W-1:0] o_flags;
	logic [LONG_W-1:0] o_program_counter;
	logic [LONG_W-1:0] o_vector_table_base;
	logic [DATA_W-1:0] o_stack_pointer;
	// Reference model: banked registers, then the unbanked ones
	logic [15:0] bk [2][7] = '{default: 16'h0};
	logic [19:0] vtb = 20'h0;
	logic [19:0] pc = 20'h0;
	logic [15:0] user_stack_pointer = 16'h0;
	logic [15:0] interrupt_stack_pointer = 16'h0;
	logic [15:0] sb = 16'h0;
	logic [10:0] cpu_flags = 11'h0;
	logic [5:0] nums [5] = '{6'h00, 6'h1f, 6'h20, 6'h3f, 6'h00};
	logic [4:0] a;
	logic [31:0] d;
	integer seed = 17;
	int miscompares = 0;
	int checks = 0;

	cpu_register_set dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
		.i_re(i_re), .o_rdata(o_rdata), .i_alu_flag_we(i_alu_flag_we), .i_alu_carry(i_alu_carry),
		.i_alu_overflow(i_alu_overflow), .i_alu_result(i_alu_result), .i_int_req(i_int_req),
		.i_int_prio(i_int_prio), .i_hw_int_accept(i_hw_int_accept), .i_sw_int_exec(i_sw_int_exec),
		.i_sw_int_num(i_sw_int_num), .o_int_enabled(o_int_enabled), .o_flags(o_flags),
		.o_program_counter(o_program_counter), .o_vector_table_base(o_vector_table_base),
		.o_stack_pointer(o_stack_pointer));

	// 200 MHz clock
	always #2.5 i_clk = ~i_clk;

	// Compare, count, report at once
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Single exit point of the run
	task automatic end_sim();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Expected read data; unmapped indices read zero
	function automatic logic [31:0] exp_rd(input logic [4:0] ra);
		logic b;
		b = cpu_flags[FLG_BANK];
		if (ra <= IDX_FRAME_BASE) return {16'h0, bk[b][ra]};
		case (ra)
			IDX_VECTOR_TABLE_BASE: return {12'h0, vtb};
			IDX_PROGRAM_COUNTER: return {12'h0, pc};
			IDX_USER_STACK_POINTER: return {16'h0, user_stack_pointer};
			IDX_INTERRUPT_STACK_POINTER: return {16'h0, interrupt_stack_pointer};
			IDX_STATIC_BASE: return {16'h0, sb};
			IDX_CPU_FLAGS: return {21'h0, cpu_flags};
			IDX_DATA_REG_0_HIGH_BYTE: return {24'h0, bk[b][0][15:8]};
			IDX_DATA_REG_0_LOW_BYTE: return {24'h0, bk[b][0][7:0]};
			IDX_DATA_REG_1_HIGH_BYTE: return {24'h0, bk[b][1][15:8]};
			IDX_DATA_REG_1_LOW_BYTE: return {24'h0, bk[b][1][7:0]};
			IDX_DATA_PAIR_LOW: return {bk[b][2], bk[b][0]};
			IDX_DATA_PAIR_HIGH: return {bk[b][3], bk[b][1]};
			IDX_ADDR_PAIR: return {bk[b][5], bk[b][4]};
			IDX_STACK_POINTER: return {16'h0, (cpu_flags[FLG_STACK_SEL] ? user_stack_pointer : interrupt_stack_pointer)};
			default: return 32'h0;
		endcase
	endfunction

	// Model side of a software write, in the bank current before it
	function automatic void mdl_wr(input logic [4:0] wa, input logic [31:0] wd);
		logic b;
		b = cpu_flags[FLG_BANK];
		if (wa <= IDX_FRAME_BASE) bk[b][wa] = wd[15:0];
		case (wa)
			IDX_VECTOR_TABLE_BASE: vtb = wd[19:0];
			IDX_PROGRAM_COUNTER: pc = wd[19:0];
			IDX_USER_STACK_POINTER: user_stack_pointer = wd[15:0];
			IDX_INTERRUPT_STACK_POINTER: interrupt_stack_pointer = wd[15:0];
			IDX_STATIC_BASE: sb = wd[15:0];
			IDX_CPU_FLAGS: cpu_flags = wd[10:0];
			IDX_DATA_REG_0_HIGH_BYTE: bk[b][0][15:8] = wd[7:0];
			IDX_DATA_REG_0_LOW_BYTE: bk[b][0][7:0] = wd[7:0];
			IDX_DATA_REG_1_HIGH_BYTE: bk[b][1][15:8] = wd[7:0];
			IDX_DATA_REG_1_LOW_BYTE: bk[b][1][7:0] = wd[7:0];
			IDX_DATA_PAIR_LOW: {bk[b][2], bk[b][0]} = wd;
			IDX_DATA_PAIR_HIGH: {bk[b][3], bk[b][1]} = wd;
			IDX_ADDR_PAIR: {bk[b][5], bk[b][4]} = wd;
			IDX_STACK_POINTER: begin
				if (cpu_flags[FLG_STACK_SEL]) user_stack_pointer = wd[15:0];
				else interrupt_stack_pointer = wd[15:0];
			end
			default: ;
		endcase
	endfunction

	// Status outputs against the model
	task automatic outs();
		chk("flags", {21'h0, o_flags}, {21'h0, cpu_flags});
		chk("program_counter", {12'h0, o_program_counter}, {12'h0, pc});
		chk("vector_table_base", {12'h0, o_vector_table_base}, {12'h0, vtb});
		chk("stack_pointer", {16'h0, o_stack_pointer}, {16'h0, (cpu_flags[FLG_STACK_SEL] ? user_stack_pointer : interrupt_stack_pointer)});
	endtask

	// Bus cycles: one-cycle strobes, read data only in the following cycle
	task automatic wr(input logic [4:0] wa, input logic [31:0] wd);
		@(posedge i_clk);
		i_we <= 1'h1;
		i_addr <= wa;
		i_wdata <= wd;
		@(posedge i_clk);
		i_we <= 1'h0;
		mdl_wr(wa, wd);
	endtask

	task automatic rd(input logic [4:0] ra);
		@(posedge i_clk);
		i_re <= 1'h1;
		i_addr <= ra;
		@(posedge i_clk);
		i_re <= 1'h0;
		#1;
		chk("rdata", o_rdata, exp_rd(ra));
		@(posedge i_clk);
		#1;
		chk("rdata idle", o_rdata, 32'h0);
		outs();
	endtask

	// Write then read with no gap: the read sees the new value
	task automatic wr_rd(input logic [4:0] wa, input logic [31:0] wd);
		@(posedge i_clk);
		i_we <= 1'h1;
		i_addr <= wa;
		i_wdata <= wd;
		@(posedge i_clk);
		i_we <= 1'h0;
		i_re <= 1'h1;
		mdl_wr(wa, wd);
		@(posedge i_clk);
		i_re <= 1'h0;
		#1;
		chk("rdata after write", o_rdata, exp_rd(wa));
	endtask

	// ALU flag load
	task automatic alu(input logic c, input logic v, input logic [15:0] r);
		@(posedge i_clk);
		i_alu_flag_we <= 1'h1;
		i_alu_carry <= c;
		i_alu_overflow <= v;
		i_alu_result <= r;
		@(posedge i_clk);
		i_alu_flag_we <= 1'h0;
		cpu_flags[FLG_CARRY] = c;
		cpu_flags[FLG_ZERO] = (r == 16'h0);
		cpu_flags[FLG_SIGN] = r[15];
		cpu_flags[FLG_OVERFLOW] = v;
		#1;
		outs();
	endtask

	// Interrupt acceptance, hardware or software numbered n
	task automatic irq(input logic hw, input logic [5:0] n);
		@(posedge i_clk);
		i_hw_int_accept <= hw;
		i_sw_int_exec <= !hw;
		i_sw_int_num <= n;
		@(posedge i_clk);
		i_hw_int_accept <= 1'h0;
		i_sw_int_exec <= 1'h0;
		cpu_flags[FLG_INT_EN] = 1'h0;
		if (hw || n <= 6'h1f) cpu_flags[FLG_STACK_SEL] = 1'h0;
		#1;
		outs();
	endtask

	// Watchdog so that no hang outlives the run
	initial begin
		repeat (50000) @(posedge i_clk);
		miscompares++;
		end_sim();
	end

	// Main sequence
	initial begin
		repeat (3) @(posedge i_clk);
		i_arst_n <= 1'h1;
		for (int k = 0; k < 24; k++) rd(5'(k));
		// Same index in both banks must not alias
		for (int b = 0; b < 2; b++) begin
			wr(IDX_CPU_FLAGS, 32'(b) << FLG_BANK);
			wr(IDX_DATA_PAIR_LOW, 32'hdead_beef ^ 32'(b));
			rd(IDX_DATA_REG_2);
		end
		wr(IDX_CPU_FLAGS, 32'h0);
		rd(IDX_DATA_REG_0);
		// Random traffic over indices 0 to 23, unmapped 21 to 23 included
		for (int n = 0; n < 600; n++) begin
			a = 5'($unsigned($random(seed)) % 24);
			d = $random(seed);
			if (a == IDX_CPU_FLAGS) d = d & 32'h0000_07fd; // Debug and upper bits at zero
			case ($unsigned($random(seed)) % 3)
				0: wr(a, d);
				1: rd(a);
				default: wr_rd(a, d);
			endcase
		end
		// ALU corners, then random results
		alu(1'h1, 1'h1, 16'h0);
		alu(1'h0, 1'h0, 16'h8000);
		for (int n = 0; n < 40; n++) alu(1'($random(seed)), 1'($random(seed)), 16'($random(seed)));
		// Acceptance gate over every level and priority
		i_int_req <= 1'h1;
		for (int ie = 0; ie < 2; ie++) begin
			for (int processor_priority_level = 0; processor_priority_level < 8; processor_priority_level++) begin
				wr(IDX_CPU_FLAGS, (32'(processor_priority_level) << FLG_IPL_LSB) | (32'(ie) << FLG_INT_EN));
				for (int p = 0; p < 8; p++) begin
					@(posedge i_clk);
					i_int_prio <= 3'(p);
					#1;
					chk("int_enabled", 32'(o_int_enabled), 32'(ie == 1 && p > processor_priority_level));
				end
			end
		end
		@(posedge i_clk);
		i_int_req <= 1'h0;
		#1;
		chk("int_enabled idle", 32'(o_int_enabled), 32'h0);
		// Software numbers 0, 31, 32, 63, then a hardware accept, a request pending at level zero
		i_int_req <= 1'h1;
		for (int k = 0; k < 5; k++) begin
			wr(IDX_CPU_FLAGS, 32'h0000_00c0 | 32'(k % 2)); // Debug flag left clear
			irq(k == 4, nums[k]);
			chk("int_enabled after accept", 32'(o_int_enabled), 32'h0);
			rd(IDX_STACK_POINTER);
		end
		end_sim();
	end
endmodule // cpu_register_set_tb_top
`default_nettype wire
